// ---- rtl/gdc_pkg.sv ----
// Package of register offsets, field positions, reset values and gain codes for the gate driver register bank.
package gdc_pkg;

    // Register indices on the serial register port.
    localparam logic [6:0] GLOBAL_CONFIGURATION_ADDR = 7'h00;
    localparam logic [6:0] GLOBAL_STATUS_FLAGS_ADDR  = 7'h01;

    // Configuration field positions.
    localparam int CFG_FAULT_MODE_BIT   = 2;
    localparam int CFG_GAIN_LSB         = 4;
    localparam int CFG_AMP_OFF_BIT      = 6;
    localparam int CFG_TEST_MODE_BIT    = 7;
    localparam int CFG_USED_WIDTH       = 8;

    // Writable bits of the configuration word: bits 2 and 7:4.
    localparam logic [7:0]  CFG_WRITE_MASK  = 8'hF4;
    localparam logic [31:0] CFG_RESET_VALUE = 32'h0000_0000;

    // Status flag positions.
    localparam int STS_RESET_BIT     = 0;
    localparam int STS_PREWARN_BIT   = 1;
    localparam int STS_OT_BIT        = 2;
    localparam int STS_PUMP_UV_BIT   = 3;
    localparam int STS_WIDTH         = 4;

    // Status reset value: only the chip-reset flag is set after reset.
    localparam logic [3:0] STS_RESET_VALUE = 4'h1;

    // Flags that a low-then-high cycle of the enable pin clears.
    localparam logic [3:0] STS_ENABLE_CYCLE_MASK = 4'hC;

    // Gain factors delivered to the sense amplifiers.
    localparam logic [4:0] GAIN_X5  = 5'h05;
    localparam logic [4:0] GAIN_X10 = 5'h0A;
    localparam logic [4:0] GAIN_X20 = 5'h14;

endpackage

// ---- rtl/gdc_flag_cell.sv ----
// One latched status flag with set priority over clear.
`timescale 1ns/1ps
module gdc_flag_cell #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic setEvt,
    input  wire logic clrReq,
    output logic      flag
);

    // Next value of the flag.
    logic flagNxt;

    // A set in the same cycle as a clear keeps the flag set.
    always_comb
    begin
        flagNxt = flag;
        if (clrReq)
        begin
            flagNxt = 1'b0;
        end
        if (setEvt)
        begin
            flagNxt = 1'b1;
        end
    end

    // The flag register itself.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flag <= RESET_VALUE;
        end
        else
        begin
            flag <= flagNxt;
        end
    end

    a_set_wins : assert property (@(posedge sys_clk) disable iff (!rst_b) setEvt |=> flag)
        else $error("flag did not set after an event");

endmodule

// ---- rtl/gdc_config_status_regs.sv ----
// Global configuration and status register bank of a three-phase gate driver.
// What this block does
// - Fault mode picks continuous or per-event fault
// - Gain field selects five, ten or twenty
// - Bit six powers down sense amplifiers
// - Test bit turns enable pin into test
// - Configuration bits above seven are unused
// - Writing one clears flag, zero keeps
// - Enable pin cycle clears flags except two
// - Clearing short flag never re-enables MOSFET
// - Chip reset sets flag, registers reset
// - Reset flag clears only with enable high
// - Prewarning flag latches, takes no action
// - Overtemperature clear refused while still hot
// - Overtemperature flag ORed into status pin
`timescale 1ns/1ps
module gdc_config_status_regs (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Register port from the serial interface.
    input  wire logic        regWrEn,
    input  wire logic [6:0]  regAddr,
    input  wire logic [31:0] regWrData,
    output logic [31:0]      regRdData,
    // Driver enable pin level.
    input  wire logic        drvEnable,
    // Dead-time setting, low two bits pick the test source.
    input  wire logic [1:0]  deadTimeSetting,
    // Protection events from the analog side.
    input  wire logic        bridgeShutdown,
    input  wire logic        overcurrentAction,
    input  wire logic        overtempShutdown,
    input  wire logic        overtempAbove,
    input  wire logic        prewarnEvent,
    input  wire logic        pumpUndervoltage,
    input  wire logic        statusIn,
    // Controls to the analog side.
    output logic             faultOut,
    output logic [4:0]       senseGain,
    output logic             ampPowerDown,
    output logic             testOutEnable,
    output logic [1:0]       testSelect,
    output logic             statusOut,
    // Short flag clearing never touches the gate drive; exported for reference.
    output logic             shortClearGate
);

    // Stored configuration bits, upper bits unused.
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    // Enable pin history to find a low-then-high cycle.
    logic       enPrev_r;
    logic       enPrev_nxt;
    logic       sawLow_r;
    logic       sawLow_nxt;
    // Per-flag set and clear requests.
    logic [3:0] stsSet;
    logic [3:0] stsClr;
    logic [3:0] sts;
    logic       enCycle;
    logic       wrCfg;
    logic       wrSts;

    // Decodes the gain code into a factor.
    function automatic logic [4:0] gainOf(input logic [1:0] code);
        unique case (code)
            2'h0:    gainOf = gdc_pkg::GAIN_X5;
            2'h1:    gainOf = gdc_pkg::GAIN_X10;
            2'h2:    gainOf = gdc_pkg::GAIN_X10;
            2'h3:    gainOf = gdc_pkg::GAIN_X20;
        endcase
    endfunction

    // Register write decode.
    assign wrCfg = regWrEn && (regAddr == gdc_pkg::GLOBAL_CONFIGURATION_ADDR);
    assign wrSts = regWrEn && (regAddr == gdc_pkg::GLOBAL_STATUS_FLAGS_ADDR);

    // Configuration write keeps only used bits; bits 31:8 are dropped.
    always_comb
    begin
        cfg_nxt = cfg_r;
        if (wrCfg)
        begin
            cfg_nxt = regWrData[7:0] & gdc_pkg::CFG_WRITE_MASK;
        end
    end

    // Enable pin cycle detector: a low level followed by a rising edge.
    always_comb
    begin
        enPrev_nxt = drvEnable;
        sawLow_nxt = sawLow_r;
        if (!drvEnable)
        begin
            sawLow_nxt = 1'b1;
        end
        else if (!enPrev_r)
        begin
            sawLow_nxt = 1'b0;
        end
    end
    assign enCycle = drvEnable && !enPrev_r && sawLow_r;

    // Registered configuration and pin history.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_r    <= gdc_pkg::CFG_RESET_VALUE[7:0];
            enPrev_r <= 1'b1;
            sawLow_r <= 1'b0;
        end
        else
        begin
            cfg_r    <= cfg_nxt;
            enPrev_r <= enPrev_nxt;
            sawLow_r <= sawLow_nxt;
        end
    end

    // Flag set events; the chip-reset flag is set only by reset itself.
    always_comb
    begin
        stsSet = 4'h0;
        stsSet[gdc_pkg::STS_PREWARN_BIT] = prewarnEvent;
        stsSet[gdc_pkg::STS_OT_BIT]      = overtempShutdown;
        stsSet[gdc_pkg::STS_PUMP_UV_BIT] = pumpUndervoltage;
    end

    // Clear requests from write-one and from the enable pin cycle.
    always_comb
    begin
        stsClr = 4'h0;
        if (wrSts)
        begin
            stsClr = regWrData[3:0];
        end
        if (enCycle)
        begin
            stsClr = stsClr | gdc_pkg::STS_ENABLE_CYCLE_MASK;
        end
        if (!drvEnable)
        begin
            stsClr[gdc_pkg::STS_RESET_BIT] = 1'b0;
        end
        if (overtempAbove)
        begin
            stsClr[gdc_pkg::STS_OT_BIT] = 1'b0;
        end
    end

    // One latched cell per status flag.
    genvar gi;
    generate
        for (gi = 0; gi < gdc_pkg::STS_WIDTH; gi++)
        begin : g_flag
            gdc_flag_cell #(
                .RESET_VALUE (gdc_pkg::STS_RESET_VALUE[gi])
            ) u_cell (
                .sys_clk (sys_clk),
                .rst_b   (rst_b),
                .setEvt  (stsSet[gi]),
                .clrReq  (stsClr[gi]),
                .flag    (sts[gi])
            );
        end
    endgenerate

    // Read mux; unmapped addresses read zero.
    always_comb
    begin
        regRdData = 32'h0000_0000;
        if (regAddr == gdc_pkg::GLOBAL_CONFIGURATION_ADDR)
        begin
            regRdData[7:0] = cfg_r;
        end
        else if (regAddr == gdc_pkg::GLOBAL_STATUS_FLAGS_ADDR)
        begin
            regRdData[3:0] = sts;
        end
    end

    // Fault output behaviour chosen by the fault-mode bit.
    assign faultOut = cfg_r[gdc_pkg::CFG_FAULT_MODE_BIT] ? (overcurrentAction | bridgeShutdown)
                                                          : bridgeShutdown;
    // Amplifier controls.
    assign senseGain    = gainOf(cfg_r[gdc_pkg::CFG_GAIN_LSB +: 2]);
    assign ampPowerDown = cfg_r[gdc_pkg::CFG_AMP_OFF_BIT];
    // Test output on the enable pin.
    assign testOutEnable = cfg_r[gdc_pkg::CFG_TEST_MODE_BIT];
    assign testSelect    = deadTimeSetting;
    // Status pin combines the overtemperature flag.
    assign statusOut = statusIn | sts[gdc_pkg::STS_OT_BIT];
    // A flag clear gives no turn-on request.
    assign shortClearGate = 1'b0;

    // Pin sampled low at one edge and high at the next: one enable cycle.
    sequence s_pin_cycle;
        !drvEnable ##1 drvEnable;
    endsequence

    // A configuration write as the register port presents it.
    sequence s_cfg_write;
        wrCfg;
    endsequence

    // The chip-reset flag survives every clear while the pin is low.
    a_reset_keep : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!drvEnable && sts[0]) |=> sts[0])
        else $error("reset flag cleared with enable low");

    // With the pin high a write of one removes the chip-reset flag.
    a_reset_clear : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (drvEnable && wrSts && regWrData[gdc_pkg::STS_RESET_BIT]) |=> !sts[0])
        else $error("reset flag kept with enable high");

    // The first edge after reset shows the reset values of both registers.
    a_reset_state : assert property (@(posedge sys_clk)
        $rose(rst_b) |-> ((sts == gdc_pkg::STS_RESET_VALUE) && (cfg_r == gdc_pkg::CFG_RESET_VALUE[7:0])))
        else $error("registers not at reset values");

    // The overtemperature flag is held while the driver is still hot.
    a_ot_hold : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (overtempAbove && sts[2]) |=> sts[2])
        else $error("overtemperature flag cleared while hot");

    // A shutdown event latches the overtemperature flag.
    a_ot_latch : assert property (@(posedge sys_clk) disable iff (!rst_b)
        overtempShutdown |=> sts[gdc_pkg::STS_OT_BIT])
        else $error("overtemperature flag did not latch");

    // A prewarning latches its own flag.
    a_prewarn_latch : assert property (@(posedge sys_clk) disable iff (!rst_b)
        prewarnEvent |=> sts[gdc_pkg::STS_PREWARN_BIT])
        else $error("prewarning flag did not latch");

    // A prewarning alone never raises the fault output.
    a_prewarn_quiet : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (prewarnEvent && !bridgeShutdown && !overcurrentAction) |-> !faultOut)
        else $error("prewarning raised the fault output");

    // A write of one clears the pump flag when no new event arrives.
    a_w1c_clear : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wrSts && regWrData[3] && !pumpUndervoltage) |=> !sts[3])
        else $error("write one did not clear flag");

    // A write of one clears the prewarning flag when no new event arrives.
    a_w1c_prewarn : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wrSts && regWrData[1] && !prewarnEvent) |=> !sts[1])
        else $error("write one did not clear prewarning");

    // A write of zero leaves the prewarning flag alone.
    a_w0_keep : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wrSts && !regWrData[1] && !enCycle && sts[1]) |=> sts[1])
        else $error("write zero changed flag");

    // An enable cycle keeps the prewarning flag.
    a_cycle_keep : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (enCycle && !wrSts && sts[1]) |=> sts[1])
        else $error("enable cycle cleared prewarning");

    // An enable cycle with no pending event clears the upper two flags.
    a_cycle_clear : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (s_pin_cycle ##0 (!pumpUndervoltage && !overtempShutdown && !overtempAbove)) |=> (sts[3:2] == 2'h0))
        else $error("enable cycle left a flag set");

    // Unused configuration bits always read zero.
    a_cfg_upper : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (regAddr == gdc_pkg::GLOBAL_CONFIGURATION_ADDR) |-> (regRdData[31:8] == 24'h000000))
        else $error("unused configuration bits read nonzero");

    // A configuration write keeps only the stored fields.
    a_cfg_land : assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_cfg_write |=> (cfg_r == ($past(regWrData[7:0]) & gdc_pkg::CFG_WRITE_MASK)))
        else $error("configuration write did not land");

    // The amplifier power-down follows the written bit.
    a_amp_power : assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_cfg_write |=> (ampPowerDown == $past(regWrData[gdc_pkg::CFG_AMP_OFF_BIT])))
        else $error("amplifier power-down did not follow write");

    // The test output enable follows the written test bit.
    a_test_bit : assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_cfg_write |=> (testOutEnable == $past(regWrData[gdc_pkg::CFG_TEST_MODE_BIT])))
        else $error("test output did not follow write");

    // Gain code three gives the largest factor.
    a_gain_code : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cfg_r[5:4] == 2'h3) |-> (senseGain == gdc_pkg::GAIN_X20))
        else $error("gain code three not twenty");

    // Gain code zero gives the smallest factor.
    a_gain_low : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cfg_r[5:4] == 2'h0) |-> (senseGain == gdc_pkg::GAIN_X5))
        else $error("gain code zero not five");

    // The status pin shows the overtemperature flag.
    a_status_or : assert property (@(posedge sys_clk) disable iff (!rst_b)
        sts[2] |-> statusOut)
        else $error("status pin missed overtemperature");

    // In continuous mode only a bridge shutdown raises the fault output.
    a_fault_mode : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!cfg_r[2] && !bridgeShutdown) |-> !faultOut)
        else $error("fault asserted without bridge shutdown");

    // In event mode every overcurrent action raises the fault output.
    a_fault_event : assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cfg_r[2] && overcurrentAction) |-> faultOut)
        else $error("fault missed an overcurrent action");

endmodule

// ---- testbench/gdc_host_model.sv ----
// Host model that owns the register port and the driver-enable pin.
`timescale 1ns/1ps
module gdc_host_model (
    input  wire logic        sys_clk,
    output logic             regWrEn,
    output logic [6:0]       regAddr,
    output logic [31:0]      regWrData,
    output logic             drvEnable,
    input  wire logic [31:0] regRdData
);
    // The bus starts idle and the enable pin starts high.
    initial
    begin
        regWrEn = 1'b0;
        regAddr = 7'h00;
        regWrData = 32'h0;
        drvEnable = 1'b1;
    end
    // This task runs one write. The strobe drops at the next falling edge, so each write is one pulse.
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(posedge sys_clk);
        @(negedge sys_clk);
        regWrEn = 1'b0;
    endtask
    // This task releases the strobe and reads. Inverted data keeps a stale word from looking valid.
    task automatic rd(input logic [6:0] a, output logic [31:0] q);
        @(negedge sys_clk);
        regWrEn = 1'b0;
        regAddr = a;
        regWrData = ~regWrData;
        #5;
        q = regRdData;
    endtask
    // This task sets the enable pin level with the bus released.
    task automatic pin(input logic lvl);
        @(negedge sys_clk);
        regWrEn = 1'b0;
        drvEnable = lvl;
    endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench of the gate driver register bank.
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst_b, regWrEn, drvEnable, bSd, ocA, otSd, otAb, pwE, pUv, stIn;
    logic [6:0] regAddr;
    logic [31:0] regWrData, regRdData, q;
    logic [1:0] dts, tSel;
    logic fOut, aOff, tEn, stOut, gate;
    logic [4:0] gain;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    int cfg, d;
    int stsM = 1;
    logic enPrevM = 1'b1;
    // The clock runs at 20 MHz.
    always #25 sys_clk = ~sys_clk;
    gdc_config_status_regs dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .drvEnable(drvEnable), .deadTimeSetting(dts),
        .bridgeShutdown(bSd), .overcurrentAction(ocA), .overtempShutdown(otSd), .overtempAbove(otAb),
        .prewarnEvent(pwE), .pumpUndervoltage(pUv), .statusIn(stIn), .faultOut(fOut), .senseGain(gain),
        .ampPowerDown(aOff), .testOutEnable(tEn), .testSelect(tSel), .statusOut(stOut),
        .shortClearGate(gate));
    gdc_host_model host_u (.sys_clk(sys_clk), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
        .drvEnable(drvEnable), .regRdData(regRdData));
    // The compare counts every check and reports a mismatch.
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // This reads the status word and compares it with the model.
    task automatic stat(input int e);
        host_u.rd(gdc_pkg::GLOBAL_STATUS_FLAGS_ADDR, q);
        check("status", q, e);
        check("status model", q, stsM);
    endtask
    // This is the gain model: code 0 gives 5, code 3 gives 20, others give 10.
    function automatic int gainOf(input int c);
        return (c == 0) ? 5 : ((c == 3) ? 20 : 10);
    endfunction
    // Next status word from the rules: clears are applied first, then new events win.
    function automatic int nextSts(input int s, input int clr, input logic en, input logic cyc, input logic hot,
                                   input int set);
        int c;
        c = clr;
        if (cyc)
            c = c | 32'hC;
        if (!en)
            c = c & ~32'h1;
        if (hot)
            c = c & ~32'h4;
        return (s & ~c) | set;
    endfunction
    // This is the status model, stepped at every rising edge from what the design sees.
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stsM <= 1;
            enPrevM <= 1'b1;
        end
        else
        begin
            stsM <= nextSts(stsM, (regWrEn && regAddr == gdc_pkg::GLOBAL_STATUS_FLAGS_ADDR) ? regWrData[3:0] : 0,
                            drvEnable, drvEnable && !enPrevM, otAb, {pUv, otSd, pwE, 1'b0});
            enPrevM <= drvEnable;
        end
    end
    // The run ends here with the counts and the verdict.
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // A hung run is cut short.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            close_out();
        end
    end
    // This is the main sequence.
    initial
    begin
        {rst_b, bSd, ocA, otSd, otAb, pwE, pUv, stIn, dts} = '0;
        void'($urandom(96));
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        host_u.rd(gdc_pkg::GLOBAL_CONFIGURATION_ADDR, q);
        check("config", q, 0);
        stat(1);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            d = ($urandom & ~32'h30) | ((i % 4) << 4);
            dts = 2'($urandom);
            host_u.wr(gdc_pkg::GLOBAL_CONFIGURATION_ADDR, d);
            host_u.rd(gdc_pkg::GLOBAL_CONFIGURATION_ADDR, q);
            cfg = d & 32'hF4;
            check("config", q, cfg);
            check("gain", gain, gainOf(cfg[5:4]));
            check("ampOff", aOff, cfg[6]);
            check("testEn", tEn, cfg[7]);
            check("testSel", tSel, dts);
        end
        $display("test config done");
        for (int m = 0; m < 2; m++)
        begin
            host_u.wr(gdc_pkg::GLOBAL_CONFIGURATION_ADDR, m << 2);
            host_u.rd(gdc_pkg::GLOBAL_CONFIGURATION_ADDR, q);
            for (int k = 0; k < 4; k++)
            begin
                @(negedge sys_clk);
                {bSd, ocA} = 2'(k);
                #5;
                check("fault", fOut, m ? (k != 0) : bSd);
            end
        end
        {bSd, ocA} = 2'h0;
        $display("test fault done");
        {pwE, otSd, pUv, otAb} = 4'hF;
        host_u.rd(gdc_pkg::GLOBAL_STATUS_FLAGS_ADDR, q);
        {pwE, otSd, pUv} = 3'h0;
        stat(32'hF);
        check("statusOut", stOut, 1);
        host_u.pin(1'b0);
        host_u.wr(gdc_pkg::GLOBAL_STATUS_FLAGS_ADDR, 32'hF);
        stat(5);
        host_u.pin(1'b1);
        stat(5);
        {pwE, otSd, pUv, otAb} = 4'hE;
        host_u.rd(gdc_pkg::GLOBAL_STATUS_FLAGS_ADDR, q);
        {pwE, otSd, pUv} = 3'h0;
        stat(32'hF);
        host_u.pin(1'b0);
        host_u.pin(1'b1);
        stat(3);
        host_u.wr(gdc_pkg::GLOBAL_STATUS_FLAGS_ADDR, 32'h0);
        stat(3);
        host_u.wr(gdc_pkg::GLOBAL_STATUS_FLAGS_ADDR, 32'h3);
        stat(0);
        check("gate", gate, 0);
        @(negedge sys_clk);
        stIn = 1'b1;
        #5;
        check("statusOut", stOut, 1);
        stIn = 1'b0;
        pUv = 1'b1;
        host_u.wr(gdc_pkg::GLOBAL_STATUS_FLAGS_ADDR, 32'h8);
        pUv = 1'b0;
        stat(8);
        check("statusOut", stOut, 0);
        $display("test status done");
        close_out();
    end
endmodule
